// ---- aux_pll_defs.svh ----
`ifndef AUX_PLL_DEFS_SVH
`define AUX_PLL_DEFS_SVH

// Serial word geometry
`define WORD_BITS 24
`define ADDR_MSB 3
`define ADDR_LSB 0

// Word address codes in the low nibble
`define ADDR_AUX_REF_WORD 4'h7
`define ADDR_SLEEP_WORD 4'h3
`define ADDR_WAKE_WORD 4'h9

// The main frequency word is the only one with bit 0 clear
`define MAIN_WORD_BIT 0

// Field positions in the divider and pump word
`define SEL_MSB 23
`define SEL_LSB 20
`define GAIN_MSB 19
`define GAIN_LSB 16
`define DIV_MSB 15
`define DIV_LSB 4

// Loose bits in other words
`define SLEEP_BIT 23
`define WAKE_BIT 23

// Reset values
`define DIV_RESET 12'h003
`define GAIN_RESET 4'h0
`define SEL_RESET 4'h1
`define SLEEP_RESET 1'b0
`define WAKE_RESET 1'b0

`endif

// ---- aux_pll_pkg.sv ----
package aux_pll_pkg;

    typedef logic [23:0] ctrl_word_t;
    typedef logic [11:0] ref_div_t;
    typedef logic [3:0] pump_code_t;
    typedef logic [4:0] pump_mult_t;

    typedef enum logic [1:0] {
        WORD_OTHER,
        WORD_MAIN,
        WORD_SLEEP,
        WORD_AUX_REF
    } word_kind_t;

endpackage : aux_pll_pkg

// ---- serial_word_rx.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "aux_pll_defs.svh"

module serial_word_rx
    import aux_pll_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Three-wire pins
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic ser_latch,
    // Latched word
    output logic word_valid,
    output ctrl_word_t word_out
);

    logic [2:0] clk_sync_reg, clk_sync_next;
    logic [2:0] le_sync_reg, le_sync_next;
    logic [1:0] data_sync_reg, data_sync_next;
    ctrl_word_t shift_reg, shift_next;
    ctrl_word_t word_reg, word_next;
    logic valid_reg, valid_next;

    always_comb begin
        clk_sync_next = {clk_sync_reg[1:0], ser_clk};
        le_sync_next = {le_sync_reg[1:0], ser_latch};
        data_sync_next = {data_sync_reg[0], ser_data};
        shift_next = shift_reg;
        word_next = word_reg;
        valid_next = 1'b0;
        // Bits enter MSB first on a rising shift clock while the latch is low
        if (clk_sync_reg[1] && !clk_sync_reg[2] && !le_sync_reg[1]) begin
            shift_next = {shift_reg[22:0], data_sync_reg[1]};
        end
        // Rising latch commits the last 24 bits shifted
        if (le_sync_reg[1] && !le_sync_reg[2]) begin
            word_next = shift_reg;
            valid_next = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_sync_reg <= 3'h0;
            // Latch idles high; a low reset value would fake a commit at release
            le_sync_reg <= 3'h7;
            data_sync_reg <= 2'h0;
            shift_reg <= 24'h000000;
            word_reg <= 24'h000000;
            valid_reg <= 1'b0;
        end else begin
            clk_sync_reg <= clk_sync_next;
            le_sync_reg <= le_sync_next;
            data_sync_reg <= data_sync_next;
            shift_reg <= shift_next;
            word_reg <= word_next;
            valid_reg <= valid_next;
        end
    end

    assign word_valid = valid_reg;
    assign word_out = word_reg;

endmodule : serial_word_rx

`default_nettype wire

// ---- aux_pll_word_decode.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "aux_pll_defs.svh"

module aux_pll_word_decode
    import aux_pll_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Three-wire serial pins
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic ser_latch,
    // Chip enable pin
    input wire logic chip_enable,
    // Auxiliary loop control
    output logic aux_pll_run,
    output logic aux_pump_hiz,
    output logic aux_pll_sleep_bit,
    output logic auto_wake_enable,
    output ref_div_t aux_ref_divider,
    // Main pump gain
    output pump_code_t main_pump_gain_code,
    output pump_mult_t main_pump_multiple,
    // Optional word selection
    output logic [2:0] word_programmable,
    output logic select_flag0_bad
);

    logic word_valid;
    ctrl_word_t word;
    logic ce_s1_reg, ce_s1_next;
    logic ce_s2_reg, ce_s2_next;

    serial_word_rx u_rx (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .ser_clk(ser_clk),
        .ser_data(ser_data),
        .ser_latch(ser_latch),
        .word_valid(word_valid),
        .word_out(word)
    );

    // Chip enable is a pin: two flops before the power logic reads it
    always_comb begin
        ce_s1_next = chip_enable;
        ce_s2_next = ce_s1_reg;
    end

    // Reset low keeps the loop down until the pin has been seen high
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ce_s1_reg <= 1'b0;
            ce_s2_reg <= 1'b0;
        end else begin
            ce_s1_reg <= ce_s1_next;
            ce_s2_reg <= ce_s2_next;
        end
    end

    // Low nibble picks the word; shared by the decoder and the checks
    function automatic logic [3:0] word_addr(input ctrl_word_t w);
        return w[`ADDR_MSB:`ADDR_LSB];
    endfunction : word_addr

    function automatic word_kind_t classify(input ctrl_word_t w);
        word_kind_t k;
        k = WORD_OTHER;
        if (!w[`MAIN_WORD_BIT]) begin
            k = WORD_MAIN;
        end else if (word_addr(w) == `ADDR_SLEEP_WORD) begin
            k = WORD_SLEEP;
        end else if (word_addr(w) == `ADDR_AUX_REF_WORD) begin
            k = WORD_AUX_REF;
        end
        return k;
    endfunction : classify

    word_kind_t kind;
    assign kind = classify(word);

    logic sleep_reg, sleep_next;
    logic wake_reg, wake_next;
    ref_div_t div_reg, div_next;
    pump_code_t gain_reg, gain_next;
    pump_mult_t mult_reg, mult_next;
    logic [3:0] sel_reg, sel_next;
    logic run_reg, run_next;
    logic hiz_reg, hiz_next;
    logic [2:0] prog_reg, prog_next;
    logic flag0_bad_reg, flag0_bad_next;

    always_comb begin
        sleep_next = sleep_reg;
        wake_next = wake_reg;
        div_next = div_reg;
        gain_next = gain_reg;
        sel_next = sel_reg;
        if (word_valid) begin
            case (kind)
                WORD_AUX_REF: begin
                    sel_next = word[`SEL_MSB:`SEL_LSB];
                    gain_next = word[`GAIN_MSB:`GAIN_LSB];
                    div_next = word[`DIV_MSB:`DIV_LSB];
                end
                WORD_SLEEP: begin
                    sleep_next = word[`SLEEP_BIT];
                end
                WORD_MAIN: begin
                    if (wake_reg) begin
                        sleep_next = 1'b0;
                    end
                end
                default: begin
                    if (word_addr(word) == `ADDR_WAKE_WORD) begin
                        wake_next = word[`WAKE_BIT];
                    end
                end
            endcase
        end
        // Gain is a count of unit currents, so code zero still drives 1X
        mult_next = {1'b0, gain_next} + 5'h01;
        // Pin low overrides the bit; a set sleep bit also holds the loop down with the pin high
        run_next = !sleep_next && ce_s2_reg;
        hiz_next = !run_next;
        // Cleared flags leave words five to seven at their fixed defaults
        prog_next = sel_next[3:1];
        // Flag 0 must be one; a zero is only reported, not corrected
        flag0_bad_next = !sel_next[0];
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sleep_reg <= `SLEEP_RESET;
            wake_reg <= `WAKE_RESET;
            div_reg <= `DIV_RESET;
            gain_reg <= `GAIN_RESET;
            mult_reg <= 5'h01;
            sel_reg <= `SEL_RESET;
            run_reg <= 1'b0;
            hiz_reg <= 1'b1;
            prog_reg <= 3'h0;
            flag0_bad_reg <= 1'b0;
        end else begin
            sleep_reg <= sleep_next;
            wake_reg <= wake_next;
            div_reg <= div_next;
            gain_reg <= gain_next;
            mult_reg <= mult_next;
            sel_reg <= sel_next;
            run_reg <= run_next;
            hiz_reg <= hiz_next;
            prog_reg <= prog_next;
            flag0_bad_reg <= flag0_bad_next;
        end
    end

    assign aux_pll_run = run_reg;
    assign aux_pump_hiz = hiz_reg;
    assign aux_pll_sleep_bit = sleep_reg;
    assign auto_wake_enable = wake_reg;
    assign aux_ref_divider = div_reg;
    assign main_pump_gain_code = gain_reg;
    assign main_pump_multiple = mult_reg;
    assign word_programmable = prog_reg;
    assign select_flag0_bad = flag0_bad_reg;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sleep_run_a: assert property ((!sleep_next && ce_s2_reg) |=> aux_pll_run)
        else $error("auxiliary loop not running with sleep clear");
    sleep_hiz_a: assert property (aux_pll_sleep_bit |-> (!aux_pll_run && aux_pump_hiz))
        else $error("sleeping auxiliary loop still driving pump");
    auto_wake_a: assert property ((word_valid && kind == WORD_MAIN && wake_reg) |=> !aux_pll_sleep_bit)
        else $error("main word write did not clear sleep bit");
    ce_override_a: assert property ((!ce_s2_reg) |=> (!aux_pll_run && aux_pump_hiz))
        else $error("chip enable low did not power down");
    div_load_a: assert property ((word_valid && word[3:0] == 4'h7) |=> aux_ref_divider == $past(word[15:4]))
        else $error("divider field not taken from word");
    gain_mult_a: assert property (main_pump_multiple == {1'b0, main_pump_gain_code} + 5'h01)
        else $error("pump multiple not gain plus one");
    sel_flags_a: assert property ((word_valid && word[3:0] == 4'h7) |=>
        (word_programmable == $past(word[23:21]) && select_flag0_bad == !$past(word[20])))
        else $error("select flags not decoded");
    field_hold_a: assert property ((word_valid && word[3:0] == 4'h7) |=>
        (main_pump_gain_code == $past(word[19:16])) ##1 $stable(aux_ref_divider) [*2])
        else $error("gain field misplaced or divider unstable");

    // Outputs that must agree, load from their word, stay put or stay in range
    hiz_pair_a: assert property (aux_pump_hiz == !aux_pll_run)
        else $error("pump tri-state does not mirror power-down");
    sleep_load_a: assert property ((word_valid && kind == WORD_SLEEP) |=>
        aux_pll_sleep_bit == $past(word[`SLEEP_BIT]))
        else $error("sleep bit not loaded from its word");
    run_state_a: assert property ((!aux_pll_sleep_bit && $past(ce_s2_reg)) |-> aux_pll_run)
        else $error("auxiliary loop down with sleep clear and pin high");
    no_wake_a: assert property ((word_valid && kind == WORD_MAIN && !wake_reg) |=> $stable(aux_pll_sleep_bit))
        else $error("main word changed sleep bit without auto-wake");
    wake_load_a: assert property ((word_valid && word_addr(word) == `ADDR_WAKE_WORD) |=>
        auto_wake_enable == $past(word[`WAKE_BIT]))
        else $error("auto-wake bit not loaded from its word");
    foreign_word_a: assert property ((word_valid && kind == WORD_OTHER) |=>
        ($stable(aux_ref_divider) && $stable(main_pump_gain_code) && $stable(aux_pll_sleep_bit)))
        else $error("unrelated word altered divider or gain");
    gain_hold_a: assert property ((word_valid && kind != WORD_AUX_REF) |=> $stable(main_pump_gain_code))
        else $error("gain changed by another word");
    mult_span_a: assert property (main_pump_multiple >= 5'h01 && main_pump_multiple <= 5'h10)
        else $error("pump multiple outside one to sixteen");

endmodule : aux_pll_word_decode

`default_nettype wire

// ---- host_serial_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module host_serial_model
    import aux_pll_pkg::*;
(
    // Clock
    input wire logic core_clk,
    // Three-wire pins and settle pulse
    output logic ser_clk,
    output logic ser_data,
    output logic ser_latch,
    output logic word_done
);
    initial begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        ser_latch = 1'b1;
        word_done = 1'b0;
    end
    // Four core cycles a phase keeps clear of the 3-cycle minimum
    task automatic ph();
        repeat (4) @(posedge core_clk);
    endtask : ph
    // Callers keep divider 3..4095 and write words 0..4 first
    task automatic send(input ctrl_word_t w);
        ser_latch <= 1'b0;
        for (int i = 23; i >= 0; i--) begin
            ser_data <= w[i];
            ph();
            ser_clk <= 1'b1;
            ph();
            ser_clk <= 1'b0;
        end
        ph();
        ser_data <= ~w[0];
        ser_latch <= 1'b1;
        repeat (8) @(posedge core_clk);
        word_done <= 1'b1;
        @(posedge core_clk);
        word_done <= 1'b0;
    endtask : send
endmodule : host_serial_model
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb
    import aux_pll_pkg::*;
;
    logic core_clk, rst_n, chip_enable, ce_done, ser_clk, ser_data, ser_latch, word_done;
    logic aux_pll_run, aux_pump_hiz, aux_pll_sleep_bit, auto_wake_enable, select_flag0_bad;
    ref_div_t aux_ref_divider, div;
    pump_code_t main_pump_gain_code;
    pump_mult_t main_pump_multiple;
    logic [2:0] word_programmable;
    logic [28:0] exp_q[$];
    logic [28:0] seen, exp_v;
    int n_mismatch = 0;
    int compares = 0;
    int seed = 32'h24AC9185;
    logic e_sleep = 1'b0, e_wake = 1'b0, e_ce = 1'b1;
    ref_div_t e_div = 12'h003;
    pump_code_t e_gain = 4'h0;
    logic [3:0] e_flags = 4'h1;
    ctrl_word_t seq[8] = '{24'h800003, 24'h000000, 24'h800009, 24'h000010,
                           24'h800003, 24'h000003, 24'hFFFFF5, 24'hABCDEF};
    // Words zero to four, each once, before any other traffic
    ctrl_word_t boot[5] = '{24'h000000, 24'h000001, 24'h000003, 24'h100037, 24'h000009};
    assign seen = {aux_pll_run, aux_pump_hiz, aux_pll_sleep_bit, auto_wake_enable, aux_ref_divider,
                   main_pump_gain_code, main_pump_multiple, word_programmable, select_flag0_bad};

    aux_pll_word_decode u_dut (.core_clk(core_clk), .rst_n(rst_n), .ser_clk(ser_clk),
        .ser_data(ser_data), .ser_latch(ser_latch), .chip_enable(chip_enable),
        .aux_pll_run(aux_pll_run), .aux_pump_hiz(aux_pump_hiz), .aux_pll_sleep_bit(aux_pll_sleep_bit),
        .auto_wake_enable(auto_wake_enable), .aux_ref_divider(aux_ref_divider),
        .main_pump_gain_code(main_pump_gain_code), .main_pump_multiple(main_pump_multiple),
        .word_programmable(word_programmable), .select_flag0_bad(select_flag0_bad));
    host_serial_model u_host (.core_clk(core_clk), .ser_clk(ser_clk), .ser_data(ser_data),
        .ser_latch(ser_latch), .word_done(word_done));

    function automatic logic [28:0] expect_now();
        logic run;
        run = e_ce & ~e_sleep;
        return {run, ~run, e_sleep, e_wake, e_div, e_gain, {1'b0, e_gain} + 5'h01, e_flags[3:1], ~e_flags[0]};
    endfunction : expect_now

    task automatic put(input ctrl_word_t w);
        case (w[3:0])
            4'h7: {e_flags, e_gain, e_div} = w[23:4];
            4'h3: e_sleep = w[23];
            4'h9: e_wake = w[23];
            default: if (!w[0] && e_wake) e_sleep = 1'b0;
        endcase
        exp_q.push_back(expect_now());
        u_host.send(w);
    endtask : put

    task automatic set_ce(input logic v);
        chip_enable <= v;
        e_ce = v;
        exp_q.push_back(expect_now());
        repeat (6) @(posedge core_clk);
        ce_done <= 1'b1;
        @(posedge core_clk);
        ce_done <= 1'b0;
    endtask : set_ce

    task automatic results();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results

    always @(posedge core_clk) begin
        if (word_done || ce_done) begin
            exp_v = exp_q.pop_front();
            compares++;
            if (seen !== exp_v) begin
                n_mismatch++;
                $display("ERROR outputs expected %h seen %h", exp_v, seen);
            end
        end
    end

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // Sized for about 7000 cycles of traffic with wide margin
    initial begin
        #200us;
        n_mismatch++;
        results();
    end

    initial begin
        rst_n = 1'b0;
        chip_enable = 1'b1;
        ce_done = 1'b0;
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        set_ce(1'b1);
        $display("test reset values done");
        foreach (boot[i]) put(boot[i]);
        $display("test mandatory words done");
        for (int n = 0; n < 16; n++) begin
            div = (n == 0) ? 12'h003 : (n == 15) ? 12'hFFF : 12'($unsigned($random(seed)) % 4093 + 3);
            put({4'($random(seed)), 4'(n), div, 4'h7});
        end
        put(24'hF12347);
        $display("test gain and divider sweep done");
        foreach (seq[i]) put(seq[i]);
        $display("test sleep, wake and ignored words done");
        set_ce(1'b0);
        put(24'h800003);
        put(24'h000003);
        set_ce(1'b1);
        $display("test chip enable override done");
        repeat (20) @(posedge core_clk);
        results();
    end
endmodule : tb
`default_nettype wire
